// ### hw/watchdog_timeout_unit.sv
/*
  Watchdog timeout unit: control/status register, unlock sequence, mode
  decode and expiry actions, plus an event status/mask pair on a classic
  Wishbone slave.
  Assumes the oscillator and fuse arrive as pins; restart, vector-taken,
  global enable and reset-cause flag come from logic on the same clock.
*/
`timescale 1ns/1ps
`default_nettype none
module watchdog_timeout_unit #(
  parameter int unsigned BASE_OSC_CYCLES = wdog_pkg::BASE_OSC_CYCLES,
  parameter int unsigned CNT_W           = wdog_pkg::CNT_W
) (
  input  wire logic                       clock,
  input  wire logic                       srst,
  // classic wishbone slave
  input  wire logic                       wb_cyc_i,
  input  wire logic                       wb_stb_i,
  input  wire logic                       wb_we_i,
  input  wire logic [wdog_pkg::ADR_W-1:0] wb_adr_i,
  input  wire logic [3:0]                 wb_sel_i,
  input  wire logic [31:0]                wb_dat_i,
  output logic      [31:0]                wb_dat_o,
  output logic                            wb_ack_o,
  // oscillator and fuse pins
  input  wire logic                       osc_clk_pin,
  input  wire logic                       always_on_fuse,
  // core side
  input  wire logic                       wdog_reset_cause_flag,
  input  wire logic                       global_irq_enable,
  input  wire logic                       restart_strobe,
  input  wire logic                       vector_taken,
  output logic                            wdog_irq_req,
  output logic                            system_reset_req,
  output logic                            irq
);

  localparam int unsigned EW = wdog_pkg::EVT_W;
  localparam int unsigned CW = wdog_pkg::CTRL_W;

  typedef struct packed {
    logic                          timeout_flag;
    logic                          timeout_irq_enable;
    logic                          reset_enable;
    logic [wdog_pkg::PERIOD_W-1:0] period_select;
    logic [2:0]                    unlock_cnt;
    logic [EW-1:0]                 evt_status;
    logic [EW-1:0]                 evt_mask;
    logic                          ack;
    logic [31:0]                   rdata;
    logic                          sys_reset;
    logic                          osc_prev;
  } state_t;

  state_t               q;
  state_t               d;

  logic [1:0]           pins_sync;
  logic                 osc_sync;
  logic                 fuse_sync;
  logic                 osc_tick;
  logic                 expire;
  logic [CNT_W-1:0]     count;
  logic                 change_unlock;
  logic                 reset_en_eff;
  wdog_pkg::mode_t      mode;
  logic                 bus_req;
  logic                 bus_wr;
  logic                 ctrl_wr;
  logic [CW-1:0]        wv;
  logic [CW-1:0]        ctrl_rd;
  logic                 counter_restart;

  // oscillator and fuse are asynchronous to the system clock
  wdog_sync2 #(
    .W(2)
  ) u_sync (
    .clock    (clock),
    .srst     (srst),
    .async_in ({always_on_fuse, osc_clk_pin}),
    .sync_out (pins_sync)
  );

  assign osc_sync  = pins_sync[0];
  assign fuse_sync = pins_sync[1];
  assign osc_tick  = osc_sync & ~q.osc_prev;

  assign change_unlock = (q.unlock_cnt != 3'h0);
  assign reset_en_eff  = q.reset_enable | wdog_reset_cause_flag | fuse_sync;
  assign mode          = wdog_pkg::decode_mode(fuse_sync, reset_en_eff,
                                               q.timeout_irq_enable);

  assign bus_req = wb_cyc_i & wb_stb_i & ~q.ack;
  assign bus_wr  = bus_req & wb_we_i & wb_sel_i[0];
  assign ctrl_wr = bus_wr & (wb_adr_i == wdog_pkg::OFS_CTRL);
  assign wv      = wb_dat_i[CW-1:0];

  // counter starts over on restart, on every handled expiry and on reset
  assign counter_restart = restart_strobe | q.sys_reset;

  wdog_period_counter #(
    .CNT_W(CNT_W),
    .BASE (BASE_OSC_CYCLES)
  ) u_counter (
    .clock         (clock),
    .srst          (srst),
    .tick          (osc_tick),
    .run           (mode != wdog_pkg::MODE_STOPPED),
    .restart       (counter_restart),
    .period_select (q.period_select),
    .expire        (expire),
    .count         (count)
  );

  always_comb begin
    ctrl_rd                                 = '0;
    ctrl_rd[wdog_pkg::BIT_FLAG]             = q.timeout_flag;
    ctrl_rd[wdog_pkg::BIT_IRQ_EN]           = q.timeout_irq_enable;
    ctrl_rd[wdog_pkg::BIT_PERIOD_HI]        = q.period_select[wdog_pkg::PERIOD_W-1];
    ctrl_rd[wdog_pkg::BIT_UNLOCK]           = change_unlock;
    ctrl_rd[wdog_pkg::BIT_RESET_EN]         = reset_en_eff;
    ctrl_rd[wdog_pkg::PERIOD_LO_MSB:0]      = q.period_select[wdog_pkg::PERIOD_LO_MSB:0];
  end

  always_comb begin
    logic          flag_set;
    logic          flag_clr;
    logic [EW-1:0] evt_set;
    logic [EW-1:0] evt_clr;
    flag_set    = 1'b0;
    flag_clr    = 1'b0;
    evt_set     = '0;
    evt_clr     = '0;
    d           = q;
    d.ack       = bus_req;
    d.sys_reset = 1'b0;
    d.osc_prev  = osc_sync;

    if (change_unlock) begin
      d.unlock_cnt = q.unlock_cnt - 3'h1;
    end

    // control/status register write
    if (ctrl_wr) begin
      if (wv[wdog_pkg::BIT_FLAG]) begin
        flag_clr = 1'b1;
      end
      d.timeout_irq_enable = wv[wdog_pkg::BIT_IRQ_EN];
      if (wv[wdog_pkg::BIT_RESET_EN]) begin
        d.reset_enable = 1'b1;
      end else if (change_unlock && !wdog_reset_cause_flag) begin
        // held while the reset-cause flag stands
        d.reset_enable = 1'b0;
      end else if (q.reset_enable) begin
        evt_set[wdog_pkg::EVT_REFUSED] = 1'b1;
      end
      if (change_unlock) begin
        d.period_select = {wv[wdog_pkg::BIT_PERIOD_HI],
                           wv[wdog_pkg::PERIOD_LO_MSB:0]};
      end else if ({wv[wdog_pkg::BIT_PERIOD_HI], wv[wdog_pkg::PERIOD_LO_MSB:0]}
                   != q.period_select) begin
        evt_set[wdog_pkg::EVT_REFUSED] = 1'b1;
      end
      if (wv[wdog_pkg::BIT_UNLOCK]) begin
        d.unlock_cnt = wdog_pkg::UNLOCK_CYCLES;
      end
    end

    // event status: write one to clear, event mask: plain write
    if (bus_wr && (wb_adr_i == wdog_pkg::OFS_EVT_STATUS)) begin
      evt_clr = wb_dat_i[EW-1:0];
    end
    if (bus_wr && (wb_adr_i == wdog_pkg::OFS_EVT_MASK)) begin
      d.evt_mask = wb_dat_i[EW-1:0];
    end

    // interrupt vector executed
    if (vector_taken) begin
      flag_clr = 1'b1;
      if (mode == wdog_pkg::MODE_IRQ_THEN_RESET) begin
        d.timeout_irq_enable = 1'b0;
      end
    end

    // expiry action by mode
    if (expire) begin
      unique case (mode)
        wdog_pkg::MODE_STOPPED: begin
        end
        wdog_pkg::MODE_IRQ: begin
          flag_set = 1'b1;
        end
        wdog_pkg::MODE_RESET: begin
          d.sys_reset = 1'b1;
        end
        wdog_pkg::MODE_IRQ_THEN_RESET: begin
          if (q.timeout_flag) begin
            d.sys_reset = 1'b1;
          end else begin
            flag_set = 1'b1;
          end
        end
      endcase
    end

    evt_set[wdog_pkg::EVT_TIMEOUT]   = evt_set[wdog_pkg::EVT_TIMEOUT] | flag_set;
    evt_set[wdog_pkg::EVT_SYS_RESET] = evt_set[wdog_pkg::EVT_SYS_RESET] | d.sys_reset;

    // a set arriving with a clear wins
    d.timeout_flag = flag_set | (q.timeout_flag & ~flag_clr);
    d.evt_status   = evt_set | (q.evt_status & ~evt_clr);

    // fuse locks the enables
    if (fuse_sync) begin
      d.reset_enable       = 1'b1;
      d.timeout_irq_enable = 1'b0;
    end

    // read data, unmapped reads as zero
    d.rdata = '0;
    if (bus_req && !wb_we_i) begin
      unique case (wb_adr_i)
        wdog_pkg::OFS_CTRL:       d.rdata = 32'(ctrl_rd);
        wdog_pkg::OFS_EVT_STATUS: d.rdata = 32'(q.evt_status);
        wdog_pkg::OFS_EVT_MASK:   d.rdata = 32'(q.evt_mask);
        wdog_pkg::OFS_COUNT:      d.rdata = 32'(count);
        default:                  d.rdata = '0;
      endcase
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      q               <= '0;
      q.period_select <= wdog_pkg::PERIOD_RESET;
      q.evt_mask      <= wdog_pkg::EVT_MASK_RESET;
    end else begin
      q <= d;
    end
  end

  assign wb_ack_o         = q.ack;
  assign wb_dat_o         = q.rdata;
  assign wdog_irq_req     = q.timeout_flag & q.timeout_irq_enable & global_irq_enable;
  assign system_reset_req = q.sys_reset;
  assign irq              = |(q.evt_status & q.evt_mask);

endmodule : watchdog_timeout_unit
`default_nettype wire

// ### pkg/wdog_pkg.sv
/*
  Shared constants for the watchdog timeout unit: register byte offsets,
  control field positions, reset values, timing figures, the mode type and
  the period decoding functions.
  Assumes a 32-bit classic Wishbone register bus with word-aligned offsets.
*/
package wdog_pkg;

  // register map, byte addresses
  localparam int unsigned ADR_W          = 4;
  localparam logic [3:0]  OFS_CTRL       = 4'h0;
  localparam logic [3:0]  OFS_EVT_STATUS = 4'h4;
  localparam logic [3:0]  OFS_EVT_MASK   = 4'h8;
  localparam logic [3:0]  OFS_COUNT      = 4'hc;

  // control/status byte layout
  localparam int unsigned CTRL_W         = 8;
  localparam int unsigned BIT_FLAG       = 7;
  localparam int unsigned BIT_IRQ_EN     = 6;
  localparam int unsigned BIT_PERIOD_HI  = 5;
  localparam int unsigned BIT_UNLOCK     = 4;
  localparam int unsigned BIT_RESET_EN   = 3;
  localparam int unsigned PERIOD_LO_MSB  = 2;
  localparam int unsigned PERIOD_W       = 4;

  // event status / mask layout
  localparam int unsigned EVT_W          = 3;
  localparam int unsigned EVT_TIMEOUT    = 0;
  localparam int unsigned EVT_SYS_RESET  = 1;
  localparam int unsigned EVT_REFUSED    = 2;

  // reset values
  localparam logic [PERIOD_W-1:0] PERIOD_RESET = 4'h0;
  localparam logic [EVT_W-1:0]    EVT_MASK_RESET = 3'h0;

  // timing: unlock window in system clock cycles
  localparam logic [2:0]  UNLOCK_CYCLES   = 3'h4;

  // timing: shortest time-out and the oscillator that measures it
  localparam int unsigned OSC_KHZ         = 128;
  localparam int unsigned TYP_TIMEOUT_US  = 16000;
  localparam int unsigned BASE_OSC_CYCLES = TYP_TIMEOUT_US * OSC_KHZ / 1000;
  localparam logic [PERIOD_W-1:0] PERIOD_CODE_MAX = 4'h9;
  localparam int unsigned CNT_W           = 21;

  typedef enum logic [1:0] {
    MODE_STOPPED,
    MODE_IRQ,
    MODE_RESET,
    MODE_IRQ_THEN_RESET
  } mode_t;

  // reserved codes run as the longest defined period
  function automatic logic [PERIOD_W-1:0] clamp_code(input logic [PERIOD_W-1:0] code);
    return (code > PERIOD_CODE_MAX) ? PERIOD_CODE_MAX : code;
  endfunction : clamp_code

  function automatic logic [31:0] period_cycles(input logic [31:0]         base,
                                                input logic [PERIOD_W-1:0] code);
    return base << clamp_code(code);
  endfunction : period_cycles

  function automatic mode_t decode_mode(input logic fuse,
                                        input logic reset_en,
                                        input logic irq_en);
    if (fuse) begin
      return MODE_RESET;
    end
    unique case ({reset_en, irq_en})
      2'b00: return MODE_STOPPED;
      2'b01: return MODE_IRQ;
      2'b10: return MODE_RESET;
      2'b11: return MODE_IRQ_THEN_RESET;
    endcase
  endfunction : decode_mode

endpackage : wdog_pkg

// ### hw/wdog_sync2.sv
/*
  Two-flop synchroniser for a group of asynchronous levels.
  Assumes the inputs are quasi-static or slow against the clock.
*/
`timescale 1ns/1ps
`default_nettype none
module wdog_sync2 #(
  parameter int unsigned W = 2
) (
  input  wire logic         clock,
  input  wire logic         srst,
  input  wire logic [W-1:0] async_in,
  output logic      [W-1:0] sync_out
);

  typedef struct packed {
    logic [W-1:0] meta;
    logic [W-1:0] stable;
  } sync_state_t;

  sync_state_t q;
  sync_state_t d;

  always_comb begin
    d        = q;
    d.meta   = async_in;
    d.stable = q.meta;
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign sync_out = q.stable;

endmodule : wdog_sync2
`default_nettype wire

// ### hw/wdog_period_counter.sv
/*
  Time-out counter clocked by oscillator ticks; gives a one-cycle expiry
  pulse when the selected period has elapsed and then starts over.
  Assumes tick is a one-cycle pulse in the system clock domain.
*/
`timescale 1ns/1ps
`default_nettype none
module wdog_period_counter #(
  parameter int unsigned CNT_W = wdog_pkg::CNT_W,
  parameter int unsigned BASE  = wdog_pkg::BASE_OSC_CYCLES
) (
  input  wire logic                          clock,
  input  wire logic                          srst,
  input  wire logic                          tick,
  input  wire logic                          run,
  input  wire logic                          restart,
  input  wire logic [wdog_pkg::PERIOD_W-1:0] period_select,
  output logic                               expire,
  output logic      [CNT_W-1:0]              count
);

  typedef struct packed {
    logic [CNT_W-1:0] count;
    logic             expire;
  } cnt_state_t;

  cnt_state_t       q;
  cnt_state_t       d;
  logic [CNT_W-1:0] limit;
  logic [CNT_W-1:0] next_count;

  assign limit      = CNT_W'(wdog_pkg::period_cycles(BASE, period_select));
  assign next_count = q.count + CNT_W'(1);

  always_comb begin
    d        = q;
    d.expire = 1'b0;
    if (restart || !run) begin
      d.count = '0;
    end else if (tick) begin
      // a shorter period below the current count expires on the next tick
      if (next_count >= limit) begin
        d.count  = '0;
        d.expire = 1'b1;
      end else begin
        d.count = next_count;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign expire = q.expire;
  assign count  = q.count;

endmodule : wdog_period_counter
`default_nettype wire

// ### test/wdog_checker.sv
/* Port checker for the watchdog timeout unit.
   Assumes binding onto watchdog_timeout_unit, one clock domain. */
`timescale 1ns/1ps
`default_nettype none
module wdog_checker (
  input wire logic                       clock,
  input wire logic                       srst,
  input wire logic                       wb_cyc_i,
  input wire logic                       wb_stb_i,
  input wire logic                       wb_we_i,
  input wire logic [wdog_pkg::ADR_W-1:0] wb_adr_i,
  input wire logic [3:0]                 wb_sel_i,
  input wire logic [31:0]                wb_dat_i,
  input wire logic [31:0]                wb_dat_o,
  input wire logic                       wb_ack_o,
  input wire logic                       always_on_fuse,
  input wire logic                       global_irq_enable,
  input wire logic                       vector_taken,
  input wire logic                       wdog_irq_req,
  input wire logic                       system_reset_req
);
  logic       take;
  logic       rd_ctrl_q;
  logic [3:0] since_q;
  assign take = wb_cyc_i && wb_stb_i && !wb_ack_o;
  // cycles since an unlock write was taken
  always_ff @(posedge clock) begin
    if (srst) begin
      rd_ctrl_q <= 1'b0;
      since_q   <= 4'hf;
    end else begin
      if (take) rd_ctrl_q <= !wb_we_i && (wb_adr_i == wdog_pkg::OFS_CTRL);
      if (take && wb_we_i && wb_sel_i[0] && wb_dat_i[4] && (wb_adr_i == wdog_pkg::OFS_CTRL))
        since_q <= 4'h0;
      else if (since_q != 4'hf) since_q <= since_q + 4'h1;
    end
  end
  default clocking cb @(posedge clock); endclocking
  default disable iff (srst);
  ack_latency_a: assert property (take |=> wb_ack_o) else $error("ack late");
  ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack too long");
  dat_idle_a: assert property (!wb_ack_o |-> wb_dat_o == 32'h0) else $error("data not zero");
  irq_gate_a: assert property (wdog_irq_req |-> global_irq_enable) else $error("req ungated");
  reset_pulse_a: assert property (system_reset_req |=> !system_reset_req) else $error("reset long");
  vector_clear_a: assert property (vector_taken |=> !wdog_irq_req) else $error("flag kept");
  fuse_irq_off_a: assert property (always_on_fuse [*6] |-> !wdog_irq_req)
    else $error("irq under fuse");
  unlock_hold_a: assert property (wb_ack_o && rd_ctrl_q && since_q inside {[2:4]} |-> wb_dat_o[4])
    else $error("unlock gone early");
  unlock_clear_a: assert property (wb_ack_o && rd_ctrl_q && since_q >= 4'h7 |-> !wb_dat_o[4])
    else $error("unlock stuck");
endmodule : wdog_checker
bind watchdog_timeout_unit wdog_checker i_wdog_checker (
  .clock(clock), .srst(srst), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
  .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
  .wb_ack_o(wb_ack_o), .always_on_fuse(always_on_fuse), .global_irq_enable(global_irq_enable),
  .vector_taken(vector_taken), .wdog_irq_req(wdog_irq_req), .system_reset_req(system_reset_req));
`default_nettype wire

// ### test/tb_top.sv
/* Self-checking bench for the watchdog timeout unit.
   Assumes a 4-tick base period and an oscillator of ten clocks. */
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  localparam logic [3:0] CT = wdog_pkg::OFS_CTRL;
  localparam logic [3:0] ST = wdog_pkg::OFS_EVT_STATUS;
  localparam logic [3:0] MK = wdog_pkg::OFS_EVT_MASK;
  localparam logic [3:0] CN = wdog_pkg::OFS_COUNT;
  logic        clock, srst, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, osc_clk_pin, always_on_fuse;
  logic        cause, gie, restart_strobe, vector_taken, wdog_irq_req, system_reset_req, irq;
  logic [3:0]  wb_adr_i, wb_sel_i;
  logic [31:0] wb_dat_i, wb_dat_o, rd;
  int          fail_count, checks, cyc, div, t0, t1, t2;
  watchdog_timeout_unit #(.BASE_OSC_CYCLES(4)) i_watchdog_timeout_unit (
    .clock(clock), .srst(srst), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
    .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .osc_clk_pin(osc_clk_pin), .always_on_fuse(always_on_fuse),
    .wdog_reset_cause_flag(cause), .global_irq_enable(gie), .restart_strobe(restart_strobe),
    .vector_taken(vector_taken), .wdog_irq_req(wdog_irq_req),
    .system_reset_req(system_reset_req), .irq(irq));
  initial begin
    clock = 1'b0;
    forever #2 clock = ~clock;
  end
  // oscillator: one tick every ten clocks
  always @(posedge clock) begin
    cyc <= cyc + 1;
    div <= (div == 4) ? 0 : div + 1;
    if (div == 4) osc_clk_pin <= ~osc_clk_pin;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      fail_count++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic wb(input logic we, input logic [3:0] a, input logic [31:0] d, input logic [3:0] s);
    int n;
    n = 0;
    wb_cyc_i <= 1'b1; wb_stb_i <= 1'b1; wb_we_i <= we; wb_adr_i <= a; wb_dat_i <= d; wb_sel_i <= s;
    @(posedge clock);
    while (wb_ack_o !== 1'b1 && n < 20) begin
      @(posedge clock);
      n++;
    end
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0; wb_stb_i <= 1'b0;
    @(posedge clock);
    chk({31'h0, n < 20}, 32'h1);
  endtask : wb
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    wb(1'b1, a, d, 4'hf);
  endtask : wr
  task automatic rdchk(input logic [3:0] a, input logic [31:0] e);
    wb(1'b0, a, 32'h0, 4'hf);
    chk(rd, e);
  endtask : rdchk
  task automatic wait_hi(input bit rst);
    int n;
    n = 0;
    do begin
      @(posedge clock);
      n++;
    end while ((rst ? system_reset_req : wdog_irq_req) !== 1'b1 && n < 300);
    chk({31'h0, n < 300}, 32'h1);
  endtask : wait_hi
  task automatic vec;
    vector_taken <= 1'b1;
    @(posedge clock);
    vector_taken <= 1'b0;
  endtask : vec
  task automatic t_reset;
    rdchk(CT, 32'h0);
    rdchk(ST, 32'h0);
    rdchk(MK, 32'h0);
    rdchk(4'h2, 32'h0);
    wb(1'b1, CT, 32'h40, 4'he);
    rdchk(CT, 32'h0);
  endtask : t_reset
  task automatic t_lock;
    wr(CT, 32'h08);
    wr(CT, 32'h00);
    rdchk(CT, 32'h08);
    wb(1'b0, ST, 32'h0, 4'hf);
    chk({31'h0, rd[2]}, 32'h1);
    wr(ST, 32'h7);
    restart_strobe <= 1'b1;
    @(posedge clock);
    restart_strobe <= 1'b0;
    wr(CT, 32'h18);
    wr(CT, 32'h01);
    rdchk(CT, 32'h01);
    wr(CT, 32'h11);
    rdchk(CT, 32'h11);
    repeat (4) @(posedge clock);
    rdchk(CT, 32'h01);
  endtask : t_lock
  task automatic t_irq;
    wr(ST, 32'h7);
    wr(MK, 32'h1);
    gie <= 1'b1;
    wr(CT, 32'h41);
    wait_hi(1'b0);
    t0 = cyc;
    chk({31'h0, irq}, 32'h1);
    wr(CT, 32'h41);
    rdchk(CT, 32'hc1);
    gie <= 1'b0;
    repeat (2) @(posedge clock);
    chk({31'h0, wdog_irq_req}, 32'h0);
    gie <= 1'b1;
    wr(CT, 32'hc1);
    rdchk(CT, 32'h41);
    wait_hi(1'b0);
    t1 = cyc;
    vec();
    wait_hi(1'b0);
    t2 = cyc;
    chk(t1 - t0, 32'd80);
    chk(t2 - t1, 32'd80);
    vec();
    wr(ST, 32'h7);
    chk({31'h0, irq}, 32'h0);
    wr(MK, 32'h0);
    wr(CT, 32'h01);
  endtask : t_irq
  task automatic t_comb;
    wr(CT, 32'h49);
    wait_hi(1'b0);
    vec();
    wr(CT, 32'h49);
    wait_hi(1'b0);
    wait_hi(1'b1);
    vec();
    rdchk(CT, 32'h09);
    cause <= 1'b1;
    wr(CT, 32'h18);
    wr(CT, 32'h01);
    rdchk(CT, 32'h09);
    wait_hi(1'b1);
    cause <= 1'b0;
    rdchk(CT, 32'h09);
    wr(CT, 32'h18);
    wr(CT, 32'h01);
    rdchk(CT, 32'h01);
  endtask : t_comb
  task automatic t_restart;
    wr(CT, 32'h18);
    wr(CT, 32'h40);
    repeat (10) begin
      repeat (20) @(posedge clock);
      restart_strobe <= 1'b1;
      @(posedge clock);
      restart_strobe <= 1'b0;
    end
    rdchk(CT, 32'h40);
    wb(1'b0, CN, 32'h0, 4'hf);
    chk({31'h0, rd < 32'd4}, 32'h1);
    wr(CT, 32'h00);
  endtask : t_restart
  task automatic t_fuse;
    always_on_fuse <= 1'b1;
    repeat (4) @(posedge clock);
    wr(CT, 32'h40);
    rdchk(CT, 32'h08);
    wait_hi(1'b1);
  endtask : t_fuse
  task automatic end_sim;
    $display("checks %0d mismatches %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : end_sim
  initial begin
    srst = 1'b1; wb_cyc_i = 1'b0; wb_stb_i = 1'b0; wb_we_i = 1'b0; wb_adr_i = 4'h0;
    wb_sel_i = 4'h0; wb_dat_i = 32'h0; osc_clk_pin = 1'b0; always_on_fuse = 1'b0; cause = 1'b0;
    gie = 1'b0; restart_strobe = 1'b0; vector_taken = 1'b0;
    fail_count = 0; checks = 0; cyc = 0; div = 0;
    repeat (8) @(posedge clock);
    srst <= 1'b0;
    @(posedge clock);
    t_reset();
    t_lock();
    t_irq();
    t_comb();
    t_restart();
    t_fuse();
    end_sim();
  end
  initial begin
    repeat (20000) @(posedge clock);
    fail_count++;
    end_sim();
  end
endmodule : tb_top
`default_nettype wire
